// *** hw/bsf_pkg.sv ***
// Constants for the bit, shift and flag execution unit
package bsf_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int DATA_W = 8;
  localparam int IDX_W  = 3;
  localparam int OP_W   = 4;
  localparam int IO_AW  = 6;

  // ****************************************************************
  // Flag positions in the core flag register
  // ****************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_T = 6;

  localparam logic [DATA_W-1:0] FLAG_RESET = 8'h00;

  // ****************************************************************
  // Operation codes
  // ****************************************************************
  localparam logic [OP_W-1:0] OP_STACK_STORE         = 4'h0;
  localparam logic [OP_W-1:0] OP_STACK_RETRIEVE      = 4'h1;
  localparam logic [OP_W-1:0] OP_IO_BIT_FORCE_HIGH   = 4'h2;
  localparam logic [OP_W-1:0] OP_IO_BIT_FORCE_LOW    = 4'h3;
  localparam logic [OP_W-1:0] OP_LOGICAL_SHIFT_UP    = 4'h4;
  localparam logic [OP_W-1:0] OP_LOGICAL_SHIFT_DOWN  = 4'h5;
  localparam logic [OP_W-1:0] OP_ROTATE_UP_CARRY     = 4'h6;
  localparam logic [OP_W-1:0] OP_ROTATE_DOWN_CARRY   = 4'h7;
  localparam logic [OP_W-1:0] OP_SIGN_KEEPING_SHIFT  = 4'h8;
  localparam logic [OP_W-1:0] OP_NIBBLE_EXCHANGE     = 4'h9;
  localparam logic [OP_W-1:0] OP_FLAG_FORCE_HIGH     = 4'ha;
  localparam logic [OP_W-1:0] OP_FLAG_FORCE_LOW      = 4'hb;
  localparam logic [OP_W-1:0] OP_BIT_TO_TRANSFER     = 4'hc;
  localparam logic [OP_W-1:0] OP_TRANSFER_TO_BIT     = 4'hd;
  localparam logic [OP_W-1:0] OP_CARRY_FORCE_HIGH    = 4'he;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    BSF_IDLE  = 3'b001,
    BSF_STORE = 3'b010,
    BSF_FETCH = 3'b100
  } bsf_state_t;

endpackage

// *** hw/bsf_exec.sv ***
// Execution unit for stack, I/O bit, shift, rotate and flag operations
`timescale 1ns/1ps

module bsf_exec (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        op_valid,
  input  wire logic [bsf_pkg::OP_W-1:0]    op_code,
  input  wire logic [bsf_pkg::DATA_W-1:0]  src_value,
  input  wire logic [bsf_pkg::DATA_W-1:0]  dst_value,
  input  wire logic [bsf_pkg::IDX_W-1:0]   bit_index,
  input  wire logic [bsf_pkg::IO_AW-1:0]   io_addr,
  input  wire logic [bsf_pkg::DATA_W-1:0]  io_rdata,
  input  wire logic [bsf_pkg::DATA_W-1:0]  stack_rdata,
  output logic                             op_ready,
  output logic                             op_done,
  output logic                             dst_we,
  output logic [bsf_pkg::DATA_W-1:0]       dst_wdata,
  output logic                             io_we,
  output logic [bsf_pkg::IO_AW-1:0]        io_waddr,
  output logic [bsf_pkg::DATA_W-1:0]       io_wdata,
  output logic                             stack_wr,
  output logic [bsf_pkg::DATA_W-1:0]       stack_wdata,
  output logic                             stack_rd,
  output logic [bsf_pkg::DATA_W-1:0]       core_flag_register
);
  import bsf_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Returns {carry_out, result} for the five shift and rotate codes
  function automatic logic [DATA_W:0] shift_calc(
    input logic [OP_W-1:0]   code,
    input logic [DATA_W-1:0] val,
    input logic              cin
  );
    logic [DATA_W:0] r;
    r = {cin, val};
    unique case (code)
      OP_LOGICAL_SHIFT_UP:   r = {val[7], val[6:0], 1'b0};
      OP_LOGICAL_SHIFT_DOWN: r = {val[0], 1'b0, val[7:1]};
      OP_ROTATE_UP_CARRY:    r = {val[7], val[6:0], cin};
      OP_ROTATE_DOWN_CARRY:  r = {val[0], cin, val[7:1]};
      OP_SIGN_KEEPING_SHIFT: r = {val[0], val[7], val[7:1]};
      default:               r = {cin, val};
    endcase
    return r;
  endfunction

  // One-hot mask for a bit index, shared by I/O, flag and register ops
  function automatic logic [DATA_W-1:0] bit_mask(
    input logic [IDX_W-1:0] idx
  );
    logic [DATA_W-1:0] m;
    m = 8'h01 << idx;
    return m;
  endfunction

  // ****************************************************************
  // Decode
  // ****************************************************************
  bsf_state_t        state;
  bsf_state_t        next_state;
  logic              accept;
  logic              is_shift;
  logic [DATA_W:0]   shift_out;
  logic [DATA_W-1:0] mask;
  logic [DATA_W-1:0] next_flags;

  assign op_ready  = (state == BSF_IDLE);
  assign accept    = op_valid && op_ready;
  assign mask      = bit_mask(bit_index);
  assign is_shift  = (op_code == OP_LOGICAL_SHIFT_UP)
                  || (op_code == OP_LOGICAL_SHIFT_DOWN)
                  || (op_code == OP_ROTATE_UP_CARRY)
                  || (op_code == OP_ROTATE_DOWN_CARRY)
                  || (op_code == OP_SIGN_KEEPING_SHIFT);
  assign shift_out = shift_calc(op_code, dst_value,
                                core_flag_register[FLAG_C]);

  // ****************************************************************
  // Sequencer for the two-cycle stack operations
  // ****************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      BSF_IDLE: begin
        if (accept && op_code == OP_STACK_STORE) begin
          next_state = BSF_STORE;
        end else if (accept && op_code == OP_STACK_RETRIEVE) begin
          next_state = BSF_FETCH;
        end
      end
      BSF_STORE: next_state = BSF_IDLE;
      BSF_FETCH: next_state = BSF_IDLE;
      default:   next_state = BSF_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= BSF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Stack port
  // ****************************************************************
  // Source is captured at accept so a later register write cannot leak in
  logic [DATA_W-1:0] held_src;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held_src    <= 8'h00;
      stack_wr    <= 1'b0;
      stack_wdata <= 8'h00;
      stack_rd    <= 1'b0;
    end else begin
      stack_wr <= (state == BSF_STORE);
      stack_rd <= accept && (op_code == OP_STACK_RETRIEVE);
      if (accept && op_code == OP_STACK_STORE) begin
        held_src <= src_value;
      end
      if (state == BSF_STORE) begin
        stack_wdata <= held_src;
      end
    end
  end

  // ****************************************************************
  // Register file write-back
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dst_we    <= 1'b0;
      dst_wdata <= 8'h00;
    end else begin
      dst_we <= 1'b0;
      if (state == BSF_FETCH) begin
        dst_we    <= 1'b1;
        dst_wdata <= stack_rdata;
      end else if (accept && is_shift) begin
        dst_we    <= 1'b1;
        dst_wdata <= shift_out[DATA_W-1:0];
      end else if (accept && op_code == OP_NIBBLE_EXCHANGE) begin
        dst_we    <= 1'b1;
        dst_wdata <= {dst_value[3:0], dst_value[7:4]};
      end else if (accept && op_code == OP_TRANSFER_TO_BIT) begin
        dst_we    <= 1'b1;
        // Only bit b moves; the rest is written back as read
        dst_wdata <= core_flag_register[FLAG_T]
                   ? (dst_value | mask)
                   : (dst_value & ~mask);
      end
    end
  end

  // ****************************************************************
  // I/O bit write
  // ****************************************************************
  // Read-modify-write: the core supplies the current register value
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      io_we    <= 1'b0;
      io_waddr <= '0;
      io_wdata <= 8'h00;
    end else begin
      io_we <= 1'b0;
      if (accept && op_code == OP_IO_BIT_FORCE_HIGH) begin
        io_we    <= 1'b1;
        io_waddr <= io_addr;
        io_wdata <= io_rdata | mask;
      end else if (accept && op_code == OP_IO_BIT_FORCE_LOW) begin
        io_we    <= 1'b1;
        io_waddr <= io_addr;
        io_wdata <= io_rdata & ~mask;
      end
    end
  end

  // ****************************************************************
  // Core flag register
  // ****************************************************************
  always_comb begin
    next_flags = core_flag_register;
    if (accept) begin
      unique case (op_code)
        OP_LOGICAL_SHIFT_UP, OP_LOGICAL_SHIFT_DOWN,
        OP_ROTATE_UP_CARRY, OP_ROTATE_DOWN_CARRY,
        OP_SIGN_KEEPING_SHIFT: begin
          next_flags[FLAG_C] = shift_out[DATA_W];
          next_flags[FLAG_Z] = (shift_out[DATA_W-1:0] == 8'h00);
          next_flags[FLAG_N] = shift_out[DATA_W-1];
          // Overflow here means the sign bit and the carry disagree
          next_flags[FLAG_V] = shift_out[DATA_W-1] ^ shift_out[DATA_W];
        end
        OP_FLAG_FORCE_HIGH: next_flags = core_flag_register | mask;
        OP_FLAG_FORCE_LOW: next_flags = core_flag_register & ~mask;
        OP_BIT_TO_TRANSFER:
          next_flags[FLAG_T] = |(src_value & mask);
        OP_CARRY_FORCE_HIGH: next_flags[FLAG_C] = 1'b1;
        default: next_flags = core_flag_register;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      core_flag_register <= FLAG_RESET;
    end else begin
      core_flag_register <= next_flags;
    end
  end

  // ****************************************************************
  // Completion
  // ****************************************************************
  // Single-cycle ops finish one edge after accept, stack ops after two
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      op_done <= 1'b0;
    end else begin
      op_done <= (accept && op_code != OP_STACK_STORE
                         && op_code != OP_STACK_RETRIEVE)
              || (state == BSF_STORE)
              || (state == BSF_FETCH);
    end
  end

endmodule

// *** verif/bsf_exec_monitor.sv ***
// Assertion checker for the bit, shift and flag execution unit
`timescale 1ns/1ps

module bsf_exec_monitor
  import bsf_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              op_valid,
  input wire logic [OP_W-1:0]   op_code,
  input wire logic [DATA_W-1:0] src_value,
  input wire logic [DATA_W-1:0] dst_value,
  input wire logic [IDX_W-1:0]  bit_index,
  input wire logic [IO_AW-1:0]  io_addr,
  input wire logic [DATA_W-1:0] io_rdata,
  input wire logic [DATA_W-1:0] stack_rdata,
  input wire logic              op_ready,
  input wire logic              op_done,
  input wire logic              dst_we,
  input wire logic [DATA_W-1:0] dst_wdata,
  input wire logic              io_we,
  input wire logic [IO_AW-1:0]  io_waddr,
  input wire logic [DATA_W-1:0] io_wdata,
  input wire logic              stack_wr,
  input wire logic [DATA_W-1:0] stack_wdata,
  input wire logic              stack_rd,
  input wire logic [DATA_W-1:0] core_flag_register
);
  logic              acc;
  logic              sh;
  logic [DATA_W-1:0] fl;
  logic [DATA_W-1:0] d_q;
  logic [DATA_W-1:0] f_q;
  assign acc = op_valid && op_ready;
  assign sh = acc
            && op_code inside {[OP_LOGICAL_SHIFT_UP:OP_SIGN_KEEPING_SHIFT]};
  assign fl = core_flag_register;
  // Operand and flags of the accept cycle, for one-cycle results
  always_ff @(posedge clock) begin
    d_q <= dst_value;
    f_q <= fl;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_store;
    acc && op_code == OP_STACK_STORE |=> !op_ready && !stack_wr
      ##1 stack_wr && op_done && stack_wdata == $past(src_value, 2);
  endproperty
  a_store: assert property (p_store) else $error("stack store");
  property p_retr;
    acc && op_code == OP_STACK_RETRIEVE |=> stack_rd && !op_done
      ##1 dst_we && dst_wdata == $past(stack_rdata) && fl == $past(fl, 2);
  endproperty
  a_retr: assert property (p_retr) else $error("stack retrieve");
  property p_io;
    acc && op_code == OP_IO_BIT_FORCE_HIGH |=> io_we && fl == f_q
      && io_waddr == $past(io_addr)
      && io_wdata == ($past(io_rdata) | (8'h01 << $past(bit_index)));
  endproperty
  a_io: assert property (p_io) else $error("io bit high");
  property p_lsl;
    acc && op_code == OP_LOGICAL_SHIFT_UP |=> dst_we && op_done
      && dst_wdata == {d_q[6:0], 1'b0} && fl[FLAG_C] == d_q[7];
  endproperty
  a_lsl: assert property (p_lsl) else $error("shift up");
  property p_rol;
    acc && op_code == OP_ROTATE_UP_CARRY |=> fl[FLAG_C] == d_q[7]
      && dst_wdata == {d_q[6:0], f_q[FLAG_C]};
  endproperty
  a_rol: assert property (p_rol) else $error("rotate up");
  property p_asr;
    acc && op_code == OP_SIGN_KEEPING_SHIFT |=>
      dst_wdata == {d_q[7], d_q[7:1]};
  endproperty
  a_asr: assert property (p_asr) else $error("sign shift");
  property p_shf;
    sh |=> fl[FLAG_Z] == (dst_wdata == 8'h00) && fl[FLAG_N] == dst_wdata[7]
      && fl[FLAG_V] == (fl[FLAG_N] ^ fl[FLAG_C]) && fl[7:4] == f_q[7:4];
  endproperty
  a_shf: assert property (p_shf) else $error("shift flags");
  property p_swap;
    acc && op_code == OP_NIBBLE_EXCHANGE |=> fl == f_q
      && dst_wdata == {d_q[3:0], d_q[7:4]};
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap");
  property p_sec;
    acc && op_code == OP_CARRY_FORCE_HIGH |=> op_done && fl == (f_q | 8'h01);
  endproperty
  a_sec: assert property (p_sec) else $error("carry high");
  c_store: cover property (acc && op_code == OP_STACK_STORE);
  c_retr: cover property (acc && op_code == OP_STACK_RETRIEVE);
  c_shift: cover property (sh);
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the bit, shift and flag execution unit
`timescale 1ns/1ps

module tb_top;
  import bsf_pkg::*;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              op_valid = 1'b0;
  logic [OP_W-1:0]   op_code = 4'h0;
  logic [DATA_W-1:0] src_value = 8'h00;
  logic [DATA_W-1:0] dst_value = 8'h00;
  logic [IDX_W-1:0]  bit_index = 3'h0;
  logic [IO_AW-1:0]  io_addr = 6'h00;
  logic [DATA_W-1:0] io_rdata = 8'h00;
  logic [DATA_W-1:0] stack_rdata = 8'h00;
  logic              op_ready, op_done, dst_we, io_we, stack_wr, stack_rd;
  logic [DATA_W-1:0] dst_wdata, io_wdata, stack_wdata, core_flag_register;
  logic [IO_AW-1:0]  io_waddr;
  logic [DATA_W-1:0] f;
  logic [8:0]        r;
  logic [OP_W-1:0]   oc;
  logic [DATA_W-1:0] dv;
  int                num_errors = 0;
  int                n_tests = 0;
  int                lat;
  bsf_exec i_bsf_exec (
    .clock              (clock),
    .rst_n              (rst_n),
    .op_valid           (op_valid),
    .op_code            (op_code),
    .src_value          (src_value),
    .dst_value          (dst_value),
    .bit_index          (bit_index),
    .io_addr            (io_addr),
    .io_rdata           (io_rdata),
    .stack_rdata        (stack_rdata),
    .op_ready           (op_ready),
    .op_done            (op_done),
    .dst_we             (dst_we),
    .dst_wdata          (dst_wdata),
    .io_we              (io_we),
    .io_waddr           (io_waddr),
    .io_wdata           (io_wdata),
    .stack_wr           (stack_wr),
    .stack_wdata        (stack_wdata),
    .stack_rd           (stack_rd),
    .core_flag_register (core_flag_register)
  );
  initial forever #20 clock = ~clock;

  task automatic complete_run();
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One request, then a bounded wait for completion; lat counts extra cycles
  task automatic run(input logic [3:0] c, input logic [7:0] s, d,
                     input logic [2:0] b);
    @(posedge clock);
    op_code <= c;
    src_value <= s;
    dst_value <= d;
    bit_index <= b;
    op_valid <= 1'b1;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    for (lat = 0; lat < 4 && op_done !== 1'b1; lat++) begin
      @(posedge clock);
      #1;
    end
    if (op_done !== 1'b1) begin
      num_errors++;
      complete_run();
    end
  endtask

  function automatic logic [8:0] shref(input logic [3:0] c,
                                        input logic [7:0] d, input logic ci);
    case (c)
      OP_LOGICAL_SHIFT_UP:   return {d[7], d[6:0], 1'b0};
      OP_LOGICAL_SHIFT_DOWN: return {d[0], 1'b0, d[7:1]};
      OP_ROTATE_UP_CARRY:    return {d[7], d[6:0], ci};
      OP_ROTATE_DOWN_CARRY:  return {d[0], ci, d[7:1]};
      default:               return {d[0], d[7], d[7:1]};
    endcase
  endfunction

  initial begin
    repeat (20) @(posedge clock);
    chk(core_flag_register, FLAG_RESET);
    rst_n <= 1'b1;
    f = FLAG_RESET;
    for (int i = 0; i < 16; i++) begin
      oc = (i < 8) ? OP_FLAG_FORCE_HIGH : OP_FLAG_FORCE_LOW;
      run(oc, 8'h00, 8'h00, i[2:0]);
      f[i[2:0]] = (i < 8);
      chk(core_flag_register, f);
    end
    run(OP_CARRY_FORCE_HIGH, 8'h00, 8'h00, 3'h0);
    f[FLAG_C] = 1'b1;
    chk(core_flag_register, f);
    chk(lat[7:0], 8'h00);
    run(OP_BIT_TO_TRANSFER, 8'h10, 8'h00, 3'h4);
    f[FLAG_T] = 1'b1;
    chk(core_flag_register, f);
    // Shifts and rotates, carry in both states, zero and sign results
    for (int i = 0; i < 15; i++) begin
      oc = OP_LOGICAL_SHIFT_UP + OP_W'(i % 5);
      dv = (i < 5) ? 8'h81 : ((i < 10) ? 8'h40 : 8'h01);
      r = shref(oc, dv, f[FLAG_C]);
      run(oc, 8'h00, dv, 3'h0);
      chk(lat[7:0], 8'h00);
      f[FLAG_C] = r[8];
      f[FLAG_Z] = (r[7:0] == 8'h00);
      f[FLAG_N] = r[7];
      f[FLAG_V] = r[7] ^ r[8];
      chk(dst_wdata, r[7:0]);
      chk(core_flag_register, f);
    end
    run(OP_NIBBLE_EXCHANGE, 8'h00, 8'ha5, 3'h0);
    chk(dst_wdata, 8'h5a);
    chk(core_flag_register, f);
    run(OP_TRANSFER_TO_BIT, 8'h00, 8'h81, 3'h2);
    chk(dst_wdata, 8'h85);
    chk(core_flag_register, f);
    @(posedge clock);
    io_addr <= 6'h2a;
    io_rdata <= 8'h5a;
    run(OP_IO_BIT_FORCE_HIGH, 8'h00, 8'h00, 3'h0);
    chk(io_wdata, 8'h5b);
    chk({2'h0, io_waddr}, 8'h2a);
    run(OP_IO_BIT_FORCE_LOW, 8'h00, 8'h00, 3'h1);
    chk(io_wdata, 8'h58);
    chk(core_flag_register, f);
    run(OP_STACK_STORE, 8'h3c, 8'h00, 3'h0);
    chk(stack_wdata, 8'h3c);
    chk(lat[7:0], 8'h01);
    stack_rdata <= 8'hc3;
    run(OP_STACK_RETRIEVE, 8'h00, 8'h00, 3'h0);
    chk(dst_wdata, 8'hc3);
    chk(lat[7:0], 8'h01);
    chk(core_flag_register, f);
    run(4'hf, 8'hff, 8'hff, 3'h7);
    chk(core_flag_register, f);
    complete_run();
  end
endmodule

bind bsf_exec bsf_exec_monitor i_bsf_exec_monitor (
  .clock              (clock),
  .rst_n              (rst_n),
  .op_valid           (op_valid),
  .op_code            (op_code),
  .src_value          (src_value),
  .dst_value          (dst_value),
  .bit_index          (bit_index),
  .io_addr            (io_addr),
  .io_rdata           (io_rdata),
  .stack_rdata        (stack_rdata),
  .op_ready           (op_ready),
  .op_done            (op_done),
  .dst_we             (dst_we),
  .dst_wdata          (dst_wdata),
  .io_we              (io_we),
  .io_waddr           (io_waddr),
  .io_wdata           (io_wdata),
  .stack_wr           (stack_wr),
  .stack_wdata        (stack_wdata),
  .stack_rd           (stack_rd),
  .core_flag_register (core_flag_register)
);
